// ===== rtl/odac_defs.svh
`ifndef ODAC_DEFS_SVH
`define ODAC_DEFS_SVH

`define ODAC_NUM_CH 8
`define ODAC_CODE_W 8
`define ODAC_SEL_W 3
`define ODAC_WORD_W 12
`define ODAC_CODE_RST 8'h00
`define ODAC_RNG_RST 1'b0
`define ODAC_SEL_MSB 11
`define ODAC_SEL_LSB 9
`define ODAC_RNG_BIT 8
`define ODAC_CODE_MSB 7
`define ODAC_CODE_LSB 0

`endif

// ===== rtl/odac_pkg.sv
`include "odac_defs.svh"

package odac_pkg;
    typedef struct packed {
        logic range_select;
        logic [`ODAC_CODE_W-1:0] code;
    } odac_chan_s;

    typedef struct packed {
        logic [`ODAC_SEL_W-1:0] sel;
        logic range_select;
        logic [`ODAC_CODE_W-1:0] code;
    } odac_word_s;
endpackage : odac_pkg

// ===== rtl/odac_sync.sv
`timescale 1ns/1ps
`include "odac_defs.svh"

module odac_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // asynchronous level in, filtered level out
    input wire logic async_i,
    output logic level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    wire agree = (s2_q == s3_q);

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_i) begin
        s1_q <= async_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lvl_q <= RST_VAL;
        end else if (agree) begin
            lvl_q <= s3_q;
        end
    end

    assign level_o = srst_i ? RST_VAL : lvl_q;
endmodule : odac_sync

// ===== rtl/odac_serial_load_port.sv
`timescale 1ns/1ps
`include "odac_defs.svh"

// Overview of operation
// R1 - shift one data bit per serial clock fall
// R2 - command word is twelve bits long
// R3 - range bit selects one or two times span
// R4 - eight channels, each eight-bit code
// R5 - update strobe high holds outputs unchanged
// R6 - update strobe falling moves buffers to outputs
// R7 - strobe low: latch fall updates output immediately
// R8 - every channel register is double buffered
// R9 - reset places all registers in known state; odac_sync stages s1_q to s3_q have no reset
// R10 - reset clears every output code to zero
// R11 - host holds latch high, shifts msb first
// R12 - select bits decode binary to channels
// R13 - last twelve bits form the command word
module odac_serial_load_port #(
    parameter int NUM_CH = `ODAC_NUM_CH,
    parameter int WORD_W = `ODAC_WORD_W
) (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    // three-wire serial load bus
    input wire logic SER_CLK_I,
    input wire logic SER_DATA_I,
    input wire logic WORD_LATCH_STROBE_I,
    // simultaneous update control
    input wire logic OUTPUT_UPDATE_STROBE_I,
    // channel outputs, channel one at index 0
    output logic [NUM_CH-1:0][`ODAC_CODE_W-1:0] CHAN_CODE_O,
    output logic [NUM_CH-1:0] CHAN_RANGE_O,
    // pending first-stage contents for observation
    output logic [NUM_CH-1:0][`ODAC_CODE_W-1:0] PEND_CODE_O
);
    logic sclk_s;
    logic sdat_s;
    logic latch_s;
    logic upd_s;
    logic sclk_q;
    logic latch_q;
    logic upd_q;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] shift_d;
    odac_pkg::odac_chan_s pend_q [NUM_CH];
    odac_pkg::odac_chan_s out_q [NUM_CH];
    odac_pkg::odac_word_s word;

    localparam odac_pkg::odac_chan_s chan_rst = '{range_select: `ODAC_RNG_RST, code: `ODAC_CODE_RST};

    // data is sampled through the same depth as the clock, so setup keeps alignment
    // clock and latch idle high, so no false fall follows reset
    odac_sync #(
        .RST_VAL(1'b1)
    ) u_sclk (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .async_i(SER_CLK_I),
        .level_o(sclk_s)
    );

    odac_sync #(
        .RST_VAL(1'b0)
    ) u_sdat (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .async_i(SER_DATA_I),
        .level_o(sdat_s)
    );

    odac_sync #(
        .RST_VAL(1'b1)
    ) u_latch (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .async_i(WORD_LATCH_STROBE_I),
        .level_o(latch_s)
    );

    // an update fall seen just after reset only copies cleared codes
    odac_sync #(
        .RST_VAL(1'b1)
    ) u_upd (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .async_i(OUTPUT_UPDATE_STROBE_I),
        .level_o(upd_s)
    );

    function automatic logic edge_down(input logic prev, input logic now);
        edge_down = prev & ~now;
    endfunction : edge_down

    function automatic logic hit(input logic [`ODAC_SEL_W-1:0] sel, input int ch);
        hit = (sel == ch[`ODAC_SEL_W-1:0]); // R12
    endfunction : hit

    function automatic odac_pkg::odac_chan_s chan_of(input odac_pkg::odac_word_s w);
        chan_of = '{range_select: w.range_select, code: w.code};
    endfunction : chan_of

    wire sclk_fall = edge_down(sclk_q, sclk_s); // R1
    wire latch_fall = edge_down(latch_q, latch_s); // R7
    wire upd_fall = edge_down(upd_q, upd_s); // R6

    always_comb begin
        shift_d = shift_q;
        if (sclk_fall) begin
            shift_d = {shift_q[WORD_W-2:0], sdat_s}; // R1 R11
        end
    end

    // oldest of the last twelve bits is the select msb
    assign word = odac_pkg::odac_word_s'(shift_q[WORD_W-1:0]); // R2 R13

    // edge history idles high, matching the clock and latch pins at rest
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            sclk_q <= 1'b1;
            latch_q <= 1'b1;
            upd_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            latch_q <= latch_s;
            upd_q <= upd_s;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            shift_q <= '0; // R9
        end else begin
            shift_q <= shift_d;
        end
    end

    // first stage takes every latched word; second stage copies per strobe
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire sel_hit = latch_fall & hit(word.sel, g); // R12
            // a latch wins over a coincident update fall for its own channel
            wire out_load = sel_hit & ~upd_s; // R7
            wire out_copy = upd_fall & ~out_load; // R6
            odac_pkg::odac_chan_s pend_d;
            odac_pkg::odac_chan_s out_d;
            assign pend_d = sel_hit ? chan_of(word) : pend_q[g]; // R8 R5
            assign out_d = out_load ? chan_of(word) : (out_copy ? pend_q[g] : out_q[g]); // R6 R8
            always_ff @(posedge REF_CLK_I) begin
                if (SRST_I) begin
                    pend_q[g] <= chan_rst; // R9 R10
                    out_q[g] <= chan_rst; // R10
                end else begin
                    pend_q[g] <= pend_d;
                    out_q[g] <= out_d;
                end
            end
            assign CHAN_CODE_O[g] = out_q[g].code; // R4
            assign CHAN_RANGE_O[g] = out_q[g].range_select; // R3
            assign PEND_CODE_O[g] = pend_q[g].code;
        end
    endgenerate
endmodule : odac_serial_load_port

// ===== test/odac_properties.sv
`timescale 1ns/1ps
`include "odac_defs.svh"
module odac_properties #(parameter int NUM_CH = 8) (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    // strobes
    input wire logic WORD_LATCH_STROBE_I,
    input wire logic OUTPUT_UPDATE_STROBE_I,
    // outputs
    input wire logic [NUM_CH-1:0][`ODAC_CODE_W-1:0] CHAN_CODE_O,
    input wire logic [NUM_CH-1:0] CHAN_RANGE_O,
    input wire logic [NUM_CH-1:0][`ODAC_CODE_W-1:0] PEND_CODE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);
    a_reset_codes: assert property ($fell(SRST_I) |->
        CHAN_CODE_O == '0 && PEND_CODE_O == '0) else $error("codes not cleared");
    a_reset_range: assert property ($fell(SRST_I) |-> CHAN_RANGE_O == '0)
        else $error("range not cleared");
    // eight quiet cycles outlast the four to five clock answer delay
    a_hold_out: assert property (OUTPUT_UPDATE_STROBE_I [*8] |->
        $stable(CHAN_CODE_O) && $stable(CHAN_RANGE_O)) else $error("output moved");
    a_pend_idle: assert property (WORD_LATCH_STROBE_I [*8] |-> $stable(PEND_CODE_O))
        else $error("pending moved");
    a_out_match: assert property ((!OUTPUT_UPDATE_STROBE_I && WORD_LATCH_STROBE_I) [*8]
        |-> CHAN_CODE_O == PEND_CODE_O) else $error("output differs from pending");
    a_out_cause: assert property ($changed(CHAN_CODE_O) |->
        !$past(WORD_LATCH_STROBE_I, 4) || !$past(OUTPUT_UPDATE_STROBE_I, 4))
        else $error("output changed unprompted");
    a_rng_cause: assert property ($changed(CHAN_RANGE_O) |->
        !$past(WORD_LATCH_STROBE_I, 4) || !$past(OUTPUT_UPDATE_STROBE_I, 4))
        else $error("range changed unprompted");
    a_pend_cause: assert property ($changed(PEND_CODE_O) |->
        !$past(WORD_LATCH_STROBE_I, 4)) else $error("pending changed unprompted");
    c_upd: cover property ($fell(OUTPUT_UPDATE_STROBE_I));
    c_pend: cover property ($changed(PEND_CODE_O));
    c_rng: cover property ($changed(CHAN_RANGE_O));
endmodule : odac_properties
bind odac_serial_load_port odac_properties #(.NUM_CH(NUM_CH)) u_props (
    .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .WORD_LATCH_STROBE_I(WORD_LATCH_STROBE_I),
    .OUTPUT_UPDATE_STROBE_I(OUTPUT_UPDATE_STROBE_I), .CHAN_CODE_O(CHAN_CODE_O),
    .CHAN_RANGE_O(CHAN_RANGE_O), .PEND_CODE_O(PEND_CODE_O));

// ===== test/odac_host.sv
`timescale 1ns/1ps
module odac_host (
    input wire logic clk_i,
    output logic sclk_o,
    output logic sdat_o,
    output logic latch_o,
    output logic upd_o
);
    initial begin
        sclk_o = 1;
        sdat_o = 0;
        latch_o = 1;
        upd_o = 0;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step
    // serial clock stands high between bits, data set 100 ns before the fall
    task automatic shift(input logic b);
        sdat_o = b;
        step(4);
        sclk_o = 0;
        step(4);
        sclk_o = 1;
    endtask : shift
    task automatic send(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) shift(w[i]);
        sdat_o = ~sdat_o;
        step(2);
        latch_o = 0;
        step(10);
        latch_o = 1;
        step(8);
    endtask : send
    task automatic set_upd(input logic b);
        upd_o = b;
        step(10);
    endtask : set_upd
endmodule : odac_host

// ===== test/test_odac_serial_load_port.sv
`timescale 1ns/1ps
module test_odac_serial_load_port;
    typedef struct packed {
        logic [11:0] word;
        logic [2:0] ch;
        logic range_select;
        logic [7:0] code;
    } odac_row_s;
    localparam odac_row_s ROWS [8] = '{
        '{12'h05a, 3'h0, 1'h0, 8'h5a}, '{12'h3ff, 3'h1, 1'h1, 8'hff},
        '{12'h401, 3'h2, 1'h0, 8'h01}, '{12'h780, 3'h3, 1'h1, 8'h80},
        '{12'h8c3, 3'h4, 1'h0, 8'hc3}, '{12'hb3c, 3'h5, 1'h1, 8'h3c},
        '{12'hc7e, 3'h6, 1'h0, 8'h7e}, '{12'hfa5, 3'h7, 1'h1, 8'ha5}};
    logic clk = 0;
    logic srst = 1;
    wire sclk, sdat, latch, upd;
    logic [7:0][7:0] code, pend;
    logic [7:0] range_select;
    int errors = 0;
    int cmp_count = 0;
    always #12.5 clk = ~clk;
    odac_host host (.clk_i(clk), .sclk_o(sclk), .sdat_o(sdat), .latch_o(latch), .upd_o(upd));
    odac_serial_load_port dut (.REF_CLK_I(clk), .SRST_I(srst), .SER_CLK_I(sclk),
        .SER_DATA_I(sdat), .WORD_LATCH_STROBE_I(latch), .OUTPUT_UPDATE_STROBE_I(upd),
        .CHAN_CODE_O(code), .CHAN_RANGE_O(range_select), .PEND_CODE_O(pend));
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic conclude();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(negedge clk);
        srst = 0;
        host.step(6);
        cmp({code, pend}, '0);
        cmp(range_select, '0);
        $display("reset test done");
        foreach (ROWS[i]) begin
            host.send(ROWS[i].word);
            cmp(code[ROWS[i].ch], ROWS[i].code);
            cmp(range_select[ROWS[i].ch], ROWS[i].range_select);
        end
        $display("row test done");
        repeat (4) host.shift(1'b1);
        host.send(12'h2c3);
        cmp(code[1], 8'hc3);
        $display("extra bit test done");
        host.set_upd(1'b1);
        host.send(12'h0e7);
        host.send(12'he18);
        cmp({code[0], range_select[7]}, 9'h0b5);
        cmp({pend[7], pend[0]}, 16'h18e7);
        host.set_upd(1'b0);
        cmp({code[7], code[0], range_select[7]}, 17'h031ce);
        $display("update test done");
        srst = 1;
        host.step(3);
        srst = 0;
        host.step(6);
        cmp({code, pend}, '0);
        cmp(range_select, '0);
        host.send(12'h5a5);
        cmp({code[2], range_select[2]}, 9'h14b);
        $display("second reset test done");
        conclude();
    end
endmodule : test_odac_serial_load_port
